// ### hdl/irq_map.svh
// Purpose: register indices, field positions, reset values, vectors and timing
// Assumes: byte address of a register is four times its index
// Notes: included by bare name
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH
// Register indices
`define IRQ_IDX_ENABLE_HIGH 8'he2
`define IRQ_IDX_ENABLE_LOW 8'he3
`define IRQ_IDX_REQUEST_HIGH 8'he4
`define IRQ_IDX_REQUEST_LOW 8'he5
`define IRQ_IDX_EDGE_SELECT 8'he6
`define IRQ_IDX_STATUS_WORD 8'he7
// Master enable position in the status word
`define IRQ_MASTER_EN_BIT 2
// Edge select bits inside each two-bit pin field
`define IRQ_EDGE_FALL_BIT 0
`define IRQ_EDGE_RISE_BIT 1
// Reset values
`define IRQ_RST_STATUS 8'h00
`define IRQ_RST_EDGE 4'h0
`define IRQ_RST_FLAGS 7'h00
// Vector addresses
`define IRQ_VEC_RESET 16'hfffe
`define IRQ_VEC_EXT0 16'hfffa
`define IRQ_VEC_EXT1 16'hfff8
`define IRQ_VEC_TMR0 16'hfff6
`define IRQ_VEC_TMR1 16'hfff4
`define IRQ_VEC_CONV 16'hffea
`define IRQ_VEC_WDOG 16'hffe8
`define IRQ_VEC_INTERVAL 16'hffe6
// Acceptance timing: oscillator periods turned into clock cycles, rounded up
`define IRQ_CLK_PERIOD_NS 40
`define IRQ_OSC_PERIOD_NS 40
`define IRQ_ACCEPT_PERIODS 8
`define IRQ_ACCEPT_CYCLES ((`IRQ_ACCEPT_PERIODS * `IRQ_OSC_PERIOD_NS + \
  `IRQ_CLK_PERIOD_NS - 1) / `IRQ_CLK_PERIOD_NS)
`endif

// ### hdl/irq_pkg.sv
// Purpose: shared types of the interrupt controller
// Assumes: nothing
// Notes: numbers live in irq_map.svh
package irq_pkg;
  // Same-clock event pulses from the peripherals
  typedef struct packed {
    logic tmr0_match;
    logic tmr1_match;
    logic conv_done;
    logic watchdog_match;
    logic interval_overflow;
  } periph_events_t;
  // One-cycle strobes from the processor core
  typedef struct packed {
    logic instr_boundary;
    logic irq_enable_instr;
    logic irq_disable_instr;
    logic irq_return_instr;
    logic soft_break_instr;
  } core_ctl_t;
  // Answer to the processor core, all registered
  typedef struct packed {
    logic irq_pending;
    logic accept_busy;
    logic push_strobe;
    logic vector_valid;
    logic [15:0] vector_addr;
  } core_ans_t;
  // Acceptance sequencer
  typedef enum logic {SEQ_IDLE, SEQ_ACCEPT} seq_state_t;
endpackage

// ### hdl/irq_edge_detect.sv
// Purpose: synchronise one external pin and flag its selected edges
// Assumes: pin is asynchronous to clk
// Notes: output pulse is one cycle, three edges after the pin moves
`include "irq_map.svh"
module irq_edge_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  output logic edge_pulse
);
  logic meta_reg; // First synchroniser stage, read only by sync_reg
  logic sync_reg; // Second stage, safe to use
  logic prev_reg; // Previous synchronised level
  logic [2:0] fill_reg; // Blocks a false edge while the chain fills after reset

  // Two-flop synchroniser and history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
      fill_reg <= 3'h0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      fill_reg <= {fill_reg[1:0], 1'b1};
    end
  end

  // Edge qualification by the selected mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_pulse <= 1'b0;
    end else begin
      edge_pulse <= fill_reg[2] &&
        ((edge_sel[`IRQ_EDGE_RISE_BIT] && sync_reg && !prev_reg) ||
         (edge_sel[`IRQ_EDGE_FALL_BIT] && !sync_reg && prev_reg));
    end
  end

  property p_rise_seen;
    @(posedge clk) disable iff (!rst_n)
      fill_reg[2] && edge_sel[`IRQ_EDGE_RISE_BIT] && $rose(sync_reg) |=> edge_pulse;
  endproperty
  a_rise_seen: assert property (p_rise_seen) else $error("rising edge missed");
endmodule

// ### hdl/irq_priority.sv
// Purpose: fixed priority pick among gated requests
// Assumes: bit 0 is the highest priority
// Notes: purely combinational
module irq_priority #(
  parameter int N = 7,
  parameter int W = 3
) (
  input wire logic [N-1:0] req,
  output logic valid,
  output logic [W-1:0] idx
);
  // Scan from highest to lowest so the lowest index is left standing
  always_comb begin
    valid = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        valid = 1'b1;
        idx = W'(i);
      end
    end
  end
endmodule

// ### hdl/irq_controller.sv
// Purpose: interrupt controller of a small 8-bit core with Avalon-MM registers
// Assumes: peripheral and core strobes are on clk; pins are asynchronous
// Notes: one wait state on every bus access
// Behaviour
// - External pins trigger on falling, rising, or both
// - External flags sit in high request register
// - Vectoring clears the external source's flag
// - Timer match sets its timer flag
// - Conversion done sets converter flag
// - Watchdog match sets flag only if select clear
// - Interval timer overflow sets interval flag
// - Master enable is status bit 2, blocks all maskable sources
// - Disable clears, enable sets master enable
// - Service entry clears master enable
// - Return from interrupt sets master enable
// - Disabled source is never accepted
// - Reset and break bypass all enables
// - Fixed priority ext0 down to interval timer
// - Acceptance pushes state then loads source vector
// - Request flags readable and writable by software
// - Pending request held until accepted or cleared
// - Acceptance takes eight oscillator periods
// - Simultaneous requests: higher priority first
// - Edge select register sits at index e6
`include "irq_map.svh"
module irq_controller #(
  parameter int ACCEPT_CYCLES = `IRQ_ACCEPT_CYCLES,
  parameter logic [15:0] BREAK_VECTOR = 16'hffde
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_irq_pin0,
  input wire logic ext_irq_pin1,
  input wire irq_pkg::periph_events_t periph,
  input wire logic watchdog_reset_select,
  input wire irq_pkg::core_ctl_t core,
  output irq_pkg::core_ans_t core_ans,
  output logic [7:0] status_word
);
  localparam int CW = $clog2(ACCEPT_CYCLES + 1);

  logic rst_meta_reg; // Reset release stage one
  logic rst_n_sync; // Released reset used by all logic
  logic wait_reg; // Drives waitrequest
  logic [31:0] readdata_reg; // Captured read answer
  logic [6:0] req_flags_reg; // Request flags, bit 0 highest priority
  logic [6:0] req_next;
  logic [6:0] enable_reg; // Individual enables, same order
  logic [3:0] edge_sel_reg; // Two bits per external pin
  logic [7:0] status_word_reg; // Status word with master enable
  logic brk_pending_reg; // Break waiting for a boundary
  logic boot_reg; // Reset vector not yet handed out
  irq_pkg::seq_state_t state_reg;
  logic [CW-1:0] cnt_reg; // Cycles left in the acceptance sequence
  irq_pkg::core_ans_t ans_reg;
  logic [1:0] ext_edge; // Qualified edge pulses
  logic [6:0] set_ev; // Hardware set events
  logic [6:0] eff_req; // Flags gated by both enables
  logic mask_valid; // Some maskable source qualifies
  logic [2:0] grant_idx; // Winning source
  logic idle_boundary; // Core may be taken now
  logic accept_mask;
  logic accept_brk;
  logic accept_any;
  logic wr_fire; // Write takes effect this edge
  logic [7:0] rd_mux;

  // Register index match on a byte address
  function automatic logic addr_is(input logic [9:0] a, input logic [7:0] idx);
    addr_is = (a[9:2] == idx);
  endfunction
  // High byte layout: ext0 bit 7 down to timer 1 bit 4
  function automatic logic [7:0] hi_pack(input logic [6:0] v);
    hi_pack = {v[0], v[1], v[2], v[3], 4'h0};
  endfunction
  // Low byte layout: converter bit 7, watchdog bit 6, interval bit 5
  function automatic logic [7:0] lo_pack(input logic [6:0] v);
    lo_pack = {v[4], v[5], v[6], 5'h00};
  endfunction
  function automatic logic [3:0] hi_unpack(input logic [7:0] b);
    hi_unpack = {b[4], b[5], b[6], b[7]};
  endfunction
  function automatic logic [2:0] lo_unpack(input logic [7:0] b);
    lo_unpack = {b[5], b[6], b[7]};
  endfunction
  // Vector of a maskable source
  function automatic logic [15:0] vec_of(input logic [2:0] i);
    unique case (i)
      3'h0: vec_of = `IRQ_VEC_EXT0;
      3'h1: vec_of = `IRQ_VEC_EXT1;
      3'h2: vec_of = `IRQ_VEC_TMR0;
      3'h3: vec_of = `IRQ_VEC_TMR1;
      3'h4: vec_of = `IRQ_VEC_CONV;
      3'h5: vec_of = `IRQ_VEC_WDOG;
      3'h6: vec_of = `IRQ_VEC_INTERVAL;
      default: vec_of = `IRQ_VEC_RESET;
    endcase
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync <= rst_meta_reg;
    end
  end

  // One edge detector per external pin
  for (genvar g = 0; g < 2; g++) begin : g_ext
    irq_edge_detect u_edge (
      .clk(clk),
      .rst_n(rst_n_sync),
      .pin(g == 0 ? ext_irq_pin0 : ext_irq_pin1),
      .edge_sel(edge_sel_reg[2*g+1:2*g]),
      .edge_pulse(ext_edge[g])
    );
  end

  // Hardware events in priority order
  always_comb begin
    set_ev[1:0] = ext_edge;
    set_ev[2] = periph.tmr0_match;
    set_ev[3] = periph.tmr1_match;
    set_ev[4] = periph.conv_done;
    set_ev[5] = periph.watchdog_match && !watchdog_reset_select;
    set_ev[6] = periph.interval_overflow;
  end

  // Gating: flag, individual enable and master enable
  assign eff_req = req_flags_reg & enable_reg &
    {7{status_word_reg[`IRQ_MASTER_EN_BIT]}};

  irq_priority #(.N(7), .W(3)) u_prio (
    .req(eff_req),
    .valid(mask_valid),
    .idx(grant_idx)
  );

  // Acceptance only at a boundary while idle; break ignores every enable
  assign idle_boundary = core.instr_boundary && state_reg == irq_pkg::SEQ_IDLE && !boot_reg;
  assign accept_mask = idle_boundary && mask_valid;
  assign accept_brk = idle_boundary && !mask_valid && brk_pending_reg;
  assign accept_any = accept_mask || accept_brk;

  // Bus write lands on the edge where waitrequest is seen low
  assign wr_fire = avs_write && !wait_reg && avs_byteenable[0];

  // Request flags: software write, clear on vectoring, then events win
  always_comb begin
    req_next = req_flags_reg;
    if (wr_fire && addr_is(avs_address, `IRQ_IDX_REQUEST_HIGH)) begin
      req_next[3:0] = hi_unpack(avs_writedata[7:0]);
    end
    if (wr_fire && addr_is(avs_address, `IRQ_IDX_REQUEST_LOW)) begin
      req_next[6:4] = lo_unpack(avs_writedata[7:0]);
    end
    if (accept_mask) begin
      req_next[grant_idx] = 1'b0;
    end
    req_next = req_next | set_ev;
  end

  // Request flag storage
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      req_flags_reg <= `IRQ_RST_FLAGS;
    end else begin
      req_flags_reg <= req_next;
    end
  end

  // Enables and edge select
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      enable_reg <= 7'h00;
      edge_sel_reg <= `IRQ_RST_EDGE;
    end else begin
      if (wr_fire && addr_is(avs_address, `IRQ_IDX_ENABLE_HIGH)) begin
        enable_reg[3:0] <= hi_unpack(avs_writedata[7:0]);
      end
      if (wr_fire && addr_is(avs_address, `IRQ_IDX_ENABLE_LOW)) begin
        enable_reg[6:4] <= lo_unpack(avs_writedata[7:0]);
      end
      if (wr_fire && addr_is(avs_address, `IRQ_IDX_EDGE_SELECT)) begin
        edge_sel_reg <= avs_writedata[3:0];
      end
    end
  end

  // Status word; hardware updates of the master bit beat a bus write
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      status_word_reg <= `IRQ_RST_STATUS;
    end else begin
      if (wr_fire && addr_is(avs_address, `IRQ_IDX_STATUS_WORD)) begin
        status_word_reg <= avs_writedata[7:0];
      end
      if (accept_any) begin
        status_word_reg[`IRQ_MASTER_EN_BIT] <= 1'b0;
      end else if (core.irq_disable_instr) begin
        status_word_reg[`IRQ_MASTER_EN_BIT] <= 1'b0;
      end else if (core.irq_enable_instr || core.irq_return_instr) begin
        status_word_reg[`IRQ_MASTER_EN_BIT] <= 1'b1;
      end
    end
  end
  assign status_word = status_word_reg;

  // Break request waits for a free boundary; lowest rank
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      brk_pending_reg <= 1'b0;
    end else if (core.soft_break_instr) begin
      brk_pending_reg <= 1'b1;
    end else if (accept_brk) begin
      brk_pending_reg <= 1'b0;
    end
  end

  // Acceptance sequencer; core pushes return address and status on push_strobe
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg <= irq_pkg::SEQ_IDLE;
      cnt_reg <= '0;
      boot_reg <= 1'b1;
      ans_reg <= '0;
      ans_reg.vector_addr <= `IRQ_VEC_RESET;
    end else begin
      ans_reg.irq_pending <= mask_valid || brk_pending_reg;
      ans_reg.push_strobe <= accept_any;
      ans_reg.vector_valid <= 1'b0;
      unique case (state_reg)
        irq_pkg::SEQ_IDLE: begin
          if (boot_reg) begin
            // Reset vector handed out once, no gating at all
            boot_reg <= 1'b0;
            ans_reg.vector_valid <= 1'b1;
          end else if (accept_any) begin
            state_reg <= irq_pkg::SEQ_ACCEPT;
            cnt_reg <= CW'(ACCEPT_CYCLES - 1);
            ans_reg.accept_busy <= 1'b1;
            // Lowest index wins when several are pending
            ans_reg.vector_addr <= accept_mask ? vec_of(grant_idx) :
              BREAK_VECTOR;
          end
        end
        irq_pkg::SEQ_ACCEPT: begin
          if (cnt_reg == '0) begin
            state_reg <= irq_pkg::SEQ_IDLE;
            ans_reg.accept_busy <= 1'b0;
            ans_reg.vector_valid <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - CW'(1);
          end
        end
      endcase
    end
  end
  assign core_ans = ans_reg;

  // Read mux; unmapped indices answer zero
  always_comb begin
    unique case (avs_address[9:2])
      `IRQ_IDX_ENABLE_HIGH: rd_mux = hi_pack(enable_reg);
      `IRQ_IDX_ENABLE_LOW: rd_mux = lo_pack(enable_reg);
      `IRQ_IDX_REQUEST_HIGH: rd_mux = hi_pack(req_flags_reg);
      `IRQ_IDX_REQUEST_LOW: rd_mux = lo_pack(req_flags_reg);
      `IRQ_IDX_EDGE_SELECT: rd_mux = {4'h0, edge_sel_reg};
      `IRQ_IDX_STATUS_WORD: rd_mux = status_word_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // Avalon slave: one wait state, data captured while waitrequest is high
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      wait_reg <= 1'b1;
      readdata_reg <= 32'h0;
    end else begin
      wait_reg <= !((avs_read || avs_write) && wait_reg);
      if (avs_read && wait_reg) begin
        readdata_reg <= {24'h000000, rd_mux};
      end
    end
  end
  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = wait_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_sync);

  sequence s_accept;
    accept_any;
  endsequence
  sequence s_wait_vector;
    (!ans_reg.vector_valid)[*8] ##1 ans_reg.vector_valid;
  endsequence

  property p_seq_len;
    s_accept |=> s_wait_vector;
  endproperty
  a_seq_len: assert property (p_seq_len) else $error("vector not after 8 cycles");

  property p_tmr_set;
    periph.tmr0_match |=> req_flags_reg[2];
  endproperty
  a_tmr_set: assert property (p_tmr_set) else $error("timer flag not set");

  property p_wdog_block;
    watchdog_reset_select && !req_flags_reg[5] &&
      !(wr_fire && addr_is(avs_address, `IRQ_IDX_REQUEST_LOW)) |=> !req_flags_reg[5];
  endproperty
  a_wdog_block: assert property (p_wdog_block) else $error("watchdog flag set in reset mode");

  property p_masked;
    accept_mask |-> status_word_reg[`IRQ_MASTER_EN_BIT] && enable_reg[grant_idx];
  endproperty
  a_masked: assert property (p_masked) else $error("gated source accepted");

  property p_entry_clears;
    accept_any |=> !status_word_reg[`IRQ_MASTER_EN_BIT] && ans_reg.push_strobe;
  endproperty
  a_entry_clears: assert property (p_entry_clears) else $error("entry kept master enable");

  property p_return_sets;
    core.irq_return_instr && !accept_any && !core.irq_disable_instr
      |=> status_word_reg[`IRQ_MASTER_EN_BIT];
  endproperty
  a_return_sets: assert property (p_return_sets) else $error("return left master clear");

  property p_top_priority;
    accept_mask && eff_req[0] |=> ans_reg.vector_addr == `IRQ_VEC_EXT0;
  endproperty
  a_top_priority: assert property (p_top_priority) else $error("ext0 not first");

  property p_flag_cleared;
    accept_mask && grant_idx == 3'h0 && !set_ev[0] |=> !req_flags_reg[0];
  endproperty
  a_flag_cleared: assert property (p_flag_cleared) else $error("ext0 flag kept");

  property p_break_bypass;
    accept_brk |=> ans_reg.vector_addr == BREAK_VECTOR ##8 ans_reg.vector_valid;
  endproperty
  a_break_bypass: assert property (p_break_bypass) else $error("break not vectored");

  property p_hold;
    req_flags_reg[6] && !wr_fire |=> req_flags_reg[6] || $past(accept_mask);
  endproperty
  a_hold: assert property (p_hold) else $error("pending interval flag lost");
endmodule

// ### verif/core_model.sv
// Purpose: processor core stand-in that paces boundaries and logs vectors
// Assumes: op bits are one-cycle pulses from the bench on clk
// Notes: op is {enable, disable, return, break}
module core_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire irq_pkg::core_ans_t ans,
  input wire logic [3:0] op,
  output irq_pkg::core_ctl_t core,
  output logic [15:0] last_vec,
  output logic [7:0] n_vec,
  output logic [7:0] lat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pace_reg; // Boundary pacing, one every fourth cycle
  logic [7:0] run_reg; // Cycles since the push strobe
  // Core strobes; fetch halts while a vector is loading
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pace_reg <= 2'h0;
      core <= '0;
    end else begin
      pace_reg <= pace_reg + 2'h1;
      core <= {(pace_reg == 2'h3) && !ans.accept_busy, op};
    end
  end
  // Log each vector and its spacing from the push
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_reg <= 8'h00;
      n_vec <= 8'h00;
      last_vec <= 16'h0000;
      lat <= 8'h00;
    end else begin
      run_reg <= ans.push_strobe ? 8'h01 : run_reg + 8'h01;
      if (ans.vector_valid) begin
        n_vec <= n_vec + 8'h01;
        last_vec <= ans.vector_addr;
        lat <= run_reg;
      end
    end
  end
endmodule

// ### verif/irq_controller_test.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: one wait state per bus access, core model paces boundaries
// Notes: flags are often set by software writes to reach priority cases
`include "irq_map.svh"
module irq_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0; // 25 MHz
  logic rst_b = 1'b0; // Active low reset
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1; // Low lane on except in the lane test
  localparam logic [15:0] BRK_VEC = 16'hffde; // Arbitrary break vector handed to the design
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pin0 = 1'b0;
  logic pin1 = 1'b0;
  irq_pkg::periph_events_t periph = '0;
  logic wd_sel = 1'b1; // Watchdog match acts as reset
  irq_pkg::core_ctl_t core;
  irq_pkg::core_ans_t core_ans;
  logic [7:0] status_word;
  logic [3:0] op = 4'h0; // Core instruction strobes
  logic [15:0] last_vec;
  logic [7:0] n_vec;
  logic [7:0] lat;
  logic [31:0] rv; // Read value
  logic [7:0] n0; // Vector count snapshot
  int fails = 0;
  int n_checks = 0;
  logic [15:0] vecs [7] = '{`IRQ_VEC_EXT0, `IRQ_VEC_EXT1, `IRQ_VEC_TMR0,
    `IRQ_VEC_TMR1, `IRQ_VEC_CONV, `IRQ_VEC_WDOG, `IRQ_VEC_INTERVAL};
  // Half period of 20 ns
  always #20 clk = ~clk;
  irq_controller #(.BREAK_VECTOR(BRK_VEC)) u_irq_controller (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_irq_pin0(pin0), .ext_irq_pin1(pin1), .periph(periph),
    .watchdog_reset_select(wd_sel), .core(core), .core_ans(core_ans),
    .status_word(status_word));
  core_model u_core_model (.clk(clk), .rst_b(rst_b), .ans(core_ans), .op(op),
    .core(core), .last_vec(last_vec), .n_vec(n_vec), .lat(lat));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus cycle: hold the request until waitrequest is sampled low
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] d);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    chk(rv[15:0], {8'h00, exp});
  endtask
  task automatic strobe(input logic [3:0] v);
    op <= v;
    @(posedge clk);
    op <= 4'h0;
    @(posedge clk);
  endtask
  task automatic pulse(input irq_pkg::periph_events_t v);
    periph <= v;
    @(posedge clk);
    periph <= '0;
    repeat (2) @(posedge clk);
  endtask
  // Wait for the next vector, bounded; a lost one is caught by the compare
  task automatic wait_vec(input logic [15:0] exp);
    int i;
    n0 = n_vec;
    for (i = 0; i < 200 && n_vec == n0; i++) @(posedge clk);
    // A missing vector must not pass on a stale address
    chk(16'(n_vec), 16'(n0 + 8'h01));
    chk(last_vec, exp);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    wait_vec(`IRQ_VEC_RESET);
    for (int r = 8'he2; r <= 8'he7; r++) rchk(r[7:0], 8'h00);
    rchk(8'h10, 8'h00);
    // Master enable through a status write while nothing is pending
    bus(8'he7, 1'b1, 8'h04);
    rchk(8'he7, 8'h04);
    chk(16'(status_word), 16'h0004);
    bus(8'he7, 1'b1, 8'h00);
    // A write with its low byte lane off must not land
    avs_byteenable <= 4'h0;
    bus(8'he4, 1'b1, 8'hf0);
    avs_byteenable <= 4'h1;
    rchk(8'he4, 8'h00);
    bus(8'he4, 1'b1, 8'hf0);
    rchk(8'he4, 8'hf0);
    bus(8'he5, 1'b1, 8'he0);
    rchk(8'he5, 8'he0);
    bus(8'he4, 1'b1, 8'h00);
    bus(8'he5, 1'b1, 8'h00);
    pulse(5'h10);
    pulse(5'h08);
    rchk(8'he4, 8'h30);
    pulse(5'h04);
    pulse(5'h02);
    rchk(8'he5, 8'h80);
    wd_sel <= 1'b0;
    pulse(5'h02);
    pulse(5'h01);
    rchk(8'he5, 8'he0);
    // Edge modes on both pins: falling, rising, both
    for (int m = 1; m < 4; m++) begin
      bus(8'he6, 1'b1, {4'h0, m[1:0], m[1:0]});
      bus(8'he4, 1'b1, 8'h00);
      pin0 <= 1'b1;
      pin1 <= 1'b1;
      repeat (8) @(posedge clk);
      rchk(8'he4, {m[1], m[1], 6'h00});
      bus(8'he4, 1'b1, 8'h00);
      pin0 <= 1'b0;
      pin1 <= 1'b0;
      repeat (8) @(posedge clk);
      rchk(8'he4, {m[0], m[0], 6'h00});
    end
    // All seven pending; served one by one in fixed order
    bus(8'he2, 1'b1, 8'hf0);
    bus(8'he3, 1'b1, 8'he0);
    bus(8'he4, 1'b1, 8'hf0);
    for (int k = 0; k < 7; k++) begin
      strobe(4'h8);
      wait_vec(vecs[k]);
      chk(lat, 16'(8'(`IRQ_ACCEPT_CYCLES)));
      rchk(8'he7, 8'h00);
    end
    rchk(8'he4, 8'h00);
    rchk(8'he5, 8'h00);
    // Masking: individual enable, then master enable
    bus(8'he2, 1'b1, 8'h00);
    bus(8'he4, 1'b1, 8'h80);
    strobe(4'h8);
    rchk(8'he7, 8'h04);
    chk(16'(status_word), 16'h0004);
    n0 = n_vec;
    repeat (40) @(posedge clk);
    chk(n_vec, n0);
    strobe(4'h4);
    rchk(8'he7, 8'h00);
    bus(8'he2, 1'b1, 8'h80);
    repeat (40) @(posedge clk);
    chk(n_vec, n0);
    chk(16'(core_ans.irq_pending), 16'h0000);
    strobe(4'h2);
    wait_vec(`IRQ_VEC_EXT0);
    // Service clears its flag before the break test re-enables nothing
    bus(8'he4, 1'b1, 8'h00);
    strobe(4'h1);
    // Pending shows one edge after the break is latched
    repeat (2) @(posedge clk);
    chk(16'(core_ans.irq_pending), 16'h0001);
    wait_vec(BRK_VEC);
    give_verdict();
  end
endmodule
